// ---- vcif_pkg.sv ----
package vcif_pkg;
  // implemented priority bits, 5 to 7
  localparam int unsigned PRIO_BITS = 7;
  // active-priority words per group that exist
  localparam int unsigned AP_WORDS =
    (PRIO_BITS >= 7) ? 4 : ((PRIO_BITS == 6) ? 2 : 1);
  // smallest legal split value for group 0
  localparam logic [2:0] BPR_MIN = 3'(7 - PRIO_BITS);
  // shift from group priority to active-priority bit index
  localparam int unsigned AP_SHIFT = 8 - PRIO_BITS;
  localparam int unsigned AP_BITS = 128;
  // access encodings, crm and opc2 fields
  localparam logic [3:0] CRM_GRP0 = 4'h8;
  localparam logic [3:0] CRM_GRP1 = 4'h9;
  localparam logic [2:0] OPC2_BPR0 = 3'h3;
  localparam int unsigned OPC2_GRP_BIT = 2;
  // binary point field position and width
  localparam int unsigned BPR_LSB = 0;
  localparam int unsigned BPR_W = 3;
  // privilege level codes
  localparam logic [1:0] LVL_GUEST = 2'h1;
  localparam logic [31:0] AP_IDLE = 32'h0000_0000;

  typedef enum logic [2:0] {
    VCIF_OK_VIRT,
    VCIF_OK_PHYS,
    VCIF_UNDEF,
    VCIF_TRAP_GUEST,
    VCIF_TRAP_HYP
  } vcif_outcome_t;
endpackage : vcif_pkg

// ---- vcif_ap_bank.sv ----
`timescale 1ns/1ns
// one group of active-priority words, registered read data
module vcif_ap_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic set_en,
  input wire logic [6:0] set_idx,
  input wire logic drop_en,
  output logic [31:0] rdata,
  output logic any_active
);
  // ********************************
  // storage and update
  // ********************************
  logic [vcif_pkg::AP_BITS-1:0] act_r;
  logic [vcif_pkg::AP_BITS-1:0] dropped;
  logic [vcif_pkg::AP_BITS-1:0] act_evt;
  wire logic [vcif_pkg::AP_BITS-1:0] act_nxt;
  logic [31:0] rdata_r;

  // drop clears the lowest set bit, the highest active priority
  assign dropped = drop_en ? (act_r & (act_r - 1'h1)) : act_r; // [R18]
  assign act_evt = set_en ? (dropped | (128'h1 << set_idx)) : dropped;
  assign any_active = (act_r != '0); // [R1]
  assign rdata = rdata_r;

  // a register write to a word wins over ack and drop for that word
  genvar w;
  generate
    for (w = 0; w < 4; w++) begin : g_word
      assign act_nxt[w*32 +: 32] = (wr_en && addr == 2'(w)) ? wdata
        : act_evt[w*32 +: 32];
    end
  endgenerate

  // contents are left unreset on purpose, one process owns them [R2]
  always_ff @(posedge clk) begin
    act_r <= act_nxt;
  end

  // read port, value taken before this cycle's update
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else if (rd_en) begin
      rdata_r <= act_r[addr*32 +: 32];
    end
  end
endmodule : vcif_ap_bank

// ---- vcif_prio_regs.sv ----
`timescale 1ns/1ns
// Overview of operation
// R1: all-zero active-priority word means no interrupt active in that group.
// R2: active-priority contents are not forced to any value by reset.
// R3: virtual copies only reachable at non-secure guest kernel level.
// R4: group 0 encoding goes physical when fast route bit is 0.
// R5: group 1 encoding goes physical when normal route bit is 0.
// R6: word 1 of each group exists only with six or more priority bits.
// R7: words 2 and 3 need seven bits; missing words are undefined.
// R8: software writes back last read value, or zero when idle.
// R9: software restores group 0 words before group 1 words.
// R10: system register enable at 0 makes guest access undefined.
// R11: guest enable at 0 traps guest access to guest kernel level.
// R12: hypervisor cp12 trap bit sends guest access to hypervisor.
// R13: trap-all-group-0 sends group 0 virtual access to hypervisor.
// R14: trap-all-group-1 sends group 1 virtual access to hypervisor.
// R15: group 0 split value is 3 bits, upper bits read zero.
// R16: split N gives group priority bits 7 to N+1, rest subpriority.
// R17: split below minimum clamps to minimum; reset loads minimum.
// R18: acknowledge sets group priority bit, priority drop clears it.
module vcif_prio_regs (
  input wire logic clk,
  input wire logic rst,
  // access port from the core
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_crm,
  input wire logic [2:0] req_opc2,
  input wire logic [31:0] req_wdata,
  input wire logic req_nonsecure,
  input wire logic [1:0] req_level,
  // routing, enable and trap controls
  input wire logic fast_irq_route_to_virtual,
  input wire logic normal_irq_route_to_virtual,
  input wire logic sysreg_iface_enable,
  input wire logic guest_sysreg_iface_enable,
  input wire logic hyp_present,
  input wire logic hyp_cp12_trap,
  input wire logic hyp_trap_all_group0,
  input wire logic hyp_trap_all_group1,
  // virtual acknowledge and priority drop
  input wire logic ack_valid,
  input wire logic ack_group,
  input wire logic [7:0] ack_prio,
  input wire logic drop_valid,
  input wire logic drop_group,
  // response
  output logic resp_valid,
  output vcif_pkg::vcif_outcome_t resp_outcome,
  output logic [31:0] resp_rdata,
  output logic [7:0] group0_preempt_mask,
  output logic group0_active,
  output logic group1_active
);
  // ********************************
  // access decode
  // ********************************
  logic hit_g0;
  logic hit_g1;
  logic hit_bpr;
  logic hit_any;
  logic guest_ns;
  logic to_phys;
  logic tall_hit;
  logic word_missing;
  logic [1:0] word_idx;
  vcif_pkg::vcif_outcome_t outcome;

  assign hit_g0 = req_crm == vcif_pkg::CRM_GRP0 &&
                  req_opc2[vcif_pkg::OPC2_GRP_BIT];
  assign hit_g1 = req_crm == vcif_pkg::CRM_GRP1 &&
                  !req_opc2[vcif_pkg::OPC2_GRP_BIT];
  assign hit_bpr = req_crm == vcif_pkg::CRM_GRP0 &&
                   req_opc2 == vcif_pkg::OPC2_BPR0;
  assign hit_any = hit_g0 || hit_g1 || hit_bpr;
  assign word_idx = req_opc2[1:0];
  assign guest_ns = req_nonsecure && req_level == vcif_pkg::LVL_GUEST;

  // routing bit picks the copy per group [R4] [R5]
  assign to_phys = (hit_g1 ? !normal_irq_route_to_virtual
                           : !fast_irq_route_to_virtual);
  assign tall_hit = hit_g1 ? hyp_trap_all_group1 // [R14]
                           : hyp_trap_all_group0; // [R13]
  // word 1 needs six bits, words 2 and 3 need seven [R6] [R7]
  assign word_missing = !hit_bpr &&
                        32'(word_idx) >= vcif_pkg::AP_WORDS;

  // ********************************
  // outcome, checked in trap priority order
  // ********************************
  // mapping and guest level first, then enables, then the cp12 trap, then routing, then the trap-all bits, then missing words
  always_comb begin
    outcome = vcif_pkg::VCIF_OK_VIRT;
    if (!hit_any) begin
      outcome = vcif_pkg::VCIF_UNDEF;
    end else if (!guest_ns) begin
      outcome = vcif_pkg::VCIF_OK_PHYS; // [R3]
    end else if (!sysreg_iface_enable) begin
      outcome = vcif_pkg::VCIF_UNDEF; // [R10]
    end else if (!guest_sysreg_iface_enable) begin
      outcome = vcif_pkg::VCIF_TRAP_GUEST; // [R11]
    end else if (hyp_present && hyp_cp12_trap) begin
      outcome = vcif_pkg::VCIF_TRAP_HYP; // [R12]
    end else if (to_phys) begin
      outcome = vcif_pkg::VCIF_OK_PHYS; // [R4] [R5]
    end else if (tall_hit) begin
      outcome = vcif_pkg::VCIF_TRAP_HYP; // [R13] [R14]
    end else if (word_missing) begin
      outcome = vcif_pkg::VCIF_UNDEF; // [R7]
    end
  end

  logic do_virt;
  logic wr_g0;
  logic wr_g1;
  logic rd_g0;
  logic rd_g1;
  logic wr_bpr;

  assign do_virt = req_valid && outcome == vcif_pkg::VCIF_OK_VIRT;
  assign wr_g0 = do_virt && hit_g0 && req_write;
  assign wr_g1 = do_virt && hit_g1 && req_write;
  assign rd_g0 = do_virt && hit_g0 && !req_write;
  assign rd_g1 = do_virt && hit_g1 && !req_write;
  assign wr_bpr = do_virt && hit_bpr && req_write;

  // ********************************
  // group 0 split point
  // ********************************
  logic [2:0] bpr0_r;
  logic [2:0] bpr0_nxt;
  logic [2:0] bpr_wval;

  assign bpr_wval = req_wdata[vcif_pkg::BPR_LSB +: vcif_pkg::BPR_W];
  // too small a split would claim priority bits that do not exist
  assign bpr0_nxt = (bpr_wval < vcif_pkg::BPR_MIN) ? vcif_pkg::BPR_MIN
                                                   : bpr_wval; // [R17]

  // reset loads the minimum split
  always_ff @(posedge clk) begin
    if (rst) begin
      bpr0_r <= vcif_pkg::BPR_MIN; // [R17]
    end else if (wr_bpr) begin
      bpr0_r <= bpr0_nxt;
    end
  end

  // group priority keeps bits 7 down to split+1 [R16]
  assign group0_preempt_mask = 8'hfe << bpr0_r;

  // ********************************
  // acknowledge bit index
  // ********************************
  logic [7:0] ack_gprio;
  logic [6:0] ack_idx;

  // group 0 drops subpriority per split; group 1 uses the minimum
  assign ack_gprio = ack_group ? (ack_prio & (8'hfe << vcif_pkg::BPR_MIN))
                               : (ack_prio & group0_preempt_mask); // [R16]
  assign ack_idx = 7'(ack_gprio >> vcif_pkg::AP_SHIFT); // [R18]

  // ********************************
  // active-priority banks
  // ********************************
  logic [31:0] rdata_g0;
  logic [31:0] rdata_g1;

  // stored words carry no reset; software clears them first [R2]
  vcif_ap_bank u_bank_g0 (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_g0),
    .rd_en(rd_g0),
    .addr(word_idx),
    .wdata(req_wdata),
    .set_en(ack_valid && !ack_group), // [R18]
    .set_idx(ack_idx),
    .drop_en(drop_valid && !drop_group), // [R18]
    .rdata(rdata_g0),
    .any_active(group0_active) // [R1]
  );

  vcif_ap_bank u_bank_g1 (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_g1),
    .rd_en(rd_g1),
    .addr(word_idx),
    .wdata(req_wdata),
    .set_en(ack_valid && ack_group), // [R18]
    .set_idx(ack_idx),
    .drop_en(drop_valid && drop_group), // [R18]
    .rdata(rdata_g1),
    .any_active(group1_active) // [R1]
  );

  // ********************************
  // response stage
  // ********************************
  logic resp_valid_r;
  vcif_pkg::vcif_outcome_t outcome_r;
  logic [1:0] rsel_r;
  logic [2:0] bpr_rd_r;

  // one-cycle answer; read select held so data lines up with bank flops
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid_r <= 1'h0;
      outcome_r <= vcif_pkg::VCIF_UNDEF;
      rsel_r <= 2'h0;
      bpr_rd_r <= 3'h0;
    end else begin
      resp_valid_r <= req_valid;
      outcome_r <= outcome;
      rsel_r <= {hit_bpr, hit_g1} & {2{do_virt && !req_write}};
      bpr_rd_r <= bpr0_r;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_outcome = outcome_r;

  // reserved split bits read zero [R15]
  always_comb begin
    resp_rdata = 32'h0;
    if (rsel_r[1]) begin
      resp_rdata = {29'h0, bpr_rd_r}; // [R15]
    end else if (rsel_r[0]) begin
      resp_rdata = rdata_g1;
    end else if (resp_valid_r && outcome_r == vcif_pkg::VCIF_OK_VIRT) begin
      resp_rdata = rdata_g0;
    end
  end
endmodule : vcif_prio_regs

// ---- vcif_prio_regs_sva.sv ----
`timescale 1ns/1ns
// ****
// access outcome checker
// ****
module vcif_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [3:0] req_crm,
  input wire logic [2:0] req_opc2,
  input wire logic req_nonsecure,
  input wire logic [1:0] req_level,
  input wire logic fast_irq_route_to_virtual,
  input wire logic normal_irq_route_to_virtual,
  input wire logic sysreg_iface_enable,
  input wire logic guest_sysreg_iface_enable,
  input wire logic hyp_present,
  input wire logic hyp_cp12_trap,
  input wire logic hyp_trap_all_group0,
  input wire logic hyp_trap_all_group1,
  input wire vcif_pkg::vcif_outcome_t resp_outcome
);
  wire logic g0, g1, gm, en, pass;
  // mapped encodings; guest accesses that pass enables and cp12 trap
  assign g0 = req_crm == vcif_pkg::CRM_GRP0 &&
    (req_opc2[vcif_pkg::OPC2_GRP_BIT] || req_opc2 == vcif_pkg::OPC2_BPR0);
  assign g1 = req_crm == vcif_pkg::CRM_GRP1 &&
    !req_opc2[vcif_pkg::OPC2_GRP_BIT];
  assign gm = req_valid && req_nonsecure &&
    req_level == vcif_pkg::LVL_GUEST && (g0 || g1);
  assign en = gm && sysreg_iface_enable && guest_sysreg_iface_enable;
  assign pass = en && !(hyp_present && hyp_cp12_trap);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_sec; req_valid && (g0 || g1) && !gm |=>
    resp_outcome == vcif_pkg::VCIF_OK_PHYS; endproperty
  a_sec: assert property (p_sec) else $error("not physical");
  property p_unmap; req_valid && !(g0 || g1) |=>
    resp_outcome == vcif_pkg::VCIF_UNDEF; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  property p_sre; gm && !sysreg_iface_enable |=>
    resp_outcome == vcif_pkg::VCIF_UNDEF; endproperty
  a_sre: assert property (p_sre) else $error("enable off ok");
  property p_gsre; gm && sysreg_iface_enable && !guest_sysreg_iface_enable
    |=> resp_outcome == vcif_pkg::VCIF_TRAP_GUEST; endproperty
  a_gsre: assert property (p_gsre) else $error("no guest trap");
  property p_cp12; en && hyp_present && hyp_cp12_trap |=>
    resp_outcome == vcif_pkg::VCIF_TRAP_HYP; endproperty
  a_cp12: assert property (p_cp12) else $error("no cp12 trap");
  property p_fr; pass && g0 && !fast_irq_route_to_virtual |=>
    resp_outcome == vcif_pkg::VCIF_OK_PHYS; endproperty
  a_fr: assert property (p_fr) else $error("group0 route");
  property p_nr; pass && g1 && !normal_irq_route_to_virtual |=>
    resp_outcome == vcif_pkg::VCIF_OK_PHYS; endproperty
  a_nr: assert property (p_nr) else $error("group1 route");
  property p_t1; pass && g1 && normal_irq_route_to_virtual &&
    hyp_trap_all_group1 |=> resp_outcome == vcif_pkg::VCIF_TRAP_HYP;
  endproperty
  a_t1: assert property (p_t1) else $error("no group1 trap");
  property p_t0; pass && g0 && fast_irq_route_to_virtual &&
    hyp_trap_all_group0 |=> resp_outcome == vcif_pkg::VCIF_TRAP_HYP;
  endproperty
  a_t0: assert property (p_t0) else $error("no group0 trap");
endmodule : vcif_sva
bind vcif_prio_regs vcif_sva u_sva (.*);

// ---- vcif_core_model.sv ----
`timescale 1ns/1ns
// ****
// core issuing one access at a time
// ****
module vcif_core_model (
  input wire logic clk,
  input wire logic resp_valid,
  input wire vcif_pkg::vcif_outcome_t resp_outcome,
  input wire logic [31:0] resp_rdata,
  output logic req_valid,
  output logic req_write,
  output logic [3:0] req_crm,
  output logic [2:0] req_opc2,
  output logic [31:0] req_wdata
);
  initial begin
    req_valid = 1'h0;
    req_write = 1'h0;
    req_crm = 4'h0;
    req_opc2 = 3'h0;
    req_wdata = 32'h0;
  end
  // pulse request; answer read mid-cycle, 7 when none came
  task automatic acc(input logic w, input logic [3:0] c, input logic [2:0] o,
    input logic [31:0] d, output logic [2:0] oc, output logic [31:0] rd);
    @(negedge clk);
    req_valid = 1'h1;
    req_write = w;
    req_crm = c;
    req_opc2 = o;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'h0;
    req_wdata = ~d; // released data must not look held
    oc = resp_valid ? resp_outcome : 3'h7;
    rd = resp_rdata;
  endtask : acc
endmodule : vcif_core_model

// ---- tb_vcif_prio_regs.sv ----
`timescale 1ns/1ns
// ****
// register access regression
// ****
module tb_vcif_prio_regs;
  logic clk = 1'h0, rst = 1'h1, req_valid, req_write, req_nonsecure;
  logic [3:0] req_crm;
  logic [2:0] req_opc2, oc;
  logic [31:0] req_wdata, resp_rdata, rd;
  logic [1:0] req_level = vcif_pkg::LVL_GUEST;
  logic sysreg_iface_enable, guest_sysreg_iface_enable, hyp_present;
  logic hyp_cp12_trap, fast_irq_route_to_virtual, normal_irq_route_to_virtual;
  logic hyp_trap_all_group0, hyp_trap_all_group1, resp_valid;
  logic ack_valid = 1'h0, ack_group = 1'h0;
  logic drop_valid = 1'h0, drop_group = 1'h0;
  logic [7:0] ack_prio = 8'h0, group0_preempt_mask;
  logic group0_active, group1_active;
  vcif_pkg::vcif_outcome_t resp_outcome;
  int n_fail = 0, check_count = 0;
  vcif_prio_regs DUT (.*);
  vcif_core_model core (.*);
  initial forever #20 clk = ~clk;
  task chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task ax(input logic w, input logic [3:0] c, input logic [2:0] o,
    input logic [31:0] d);
    core.acc(w, c, o, d, oc, rd);
  endtask : ax
  // order: ns, enables, hyp, cp12, routes, trap-all 0 and 1
  task setc(input logic [8:0] v);
    {req_nonsecure, sysreg_iface_enable, guest_sysreg_iface_enable,
      hyp_present, hyp_cp12_trap, fast_irq_route_to_virtual,
      normal_irq_route_to_virtual, hyp_trap_all_group0,
      hyp_trap_all_group1} = v;
  endtask : setc
  // a zero write per case; refused ones must leave storage alone
  task tc(input logic [8:0] v, input logic [3:0] c, input logic [2:0] e);
    setc(v);
    ax(1'h1, c, (c == vcif_pkg::CRM_GRP1) ? 3'h0 : 3'h4, 32'h0);
    chk("outcome", 32'(oc), 32'(e));
    setc(9'h1cc);
  endtask : tc
  // ack when a is 1, priority drop otherwise
  task pulse(input logic a, input logic g, input logic [7:0] p);
    @(negedge clk);
    {ack_valid, drop_valid, ack_group, drop_group} = {a, !a, g, g};
    ack_prio = p;
    @(negedge clk);
    {ack_valid, drop_valid} = 2'b00;
  endtask : pulse
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    test_done();
  end
  initial begin
    setc(9'h1cc);
    repeat (16) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      ax(1'h1, i[2] ? 4'h9 : 4'h8, {~i[2], i[1:0]}, 32'h0);
    end
    chk("g0 act", 32'(group0_active), 32'h0);
    chk("g1 act", 32'(group1_active), 32'h0);
    ax(1'h0, vcif_pkg::CRM_GRP0, vcif_pkg::OPC2_BPR0, 32'h0);
    chk("split", rd, 32'(vcif_pkg::BPR_MIN));
    for (int n = 0; n < 7; n++) begin
      ax(1'h1, vcif_pkg::CRM_GRP0, vcif_pkg::OPC2_BPR0,
        32'hffff_fff8 | 32'(n));
      chk("mask", 32'(group0_preempt_mask), {24'h0, 8'hfe << n});
      ax(1'h0, vcif_pkg::CRM_GRP0, vcif_pkg::OPC2_BPR0, 32'h0);
      chk("split", rd, 32'(n));
    end
    ax(1'h1, vcif_pkg::CRM_GRP0, vcif_pkg::OPC2_BPR0, 32'h0);
    pulse(1'h1, 1'h0, 8'h11);
    ax(1'h0, vcif_pkg::CRM_GRP0, 3'h4, 32'h0);
    chk("ap0 w0", rd, 32'h100);
    chk("g0 act", 32'(group0_active), 32'h1);
    tc(9'h0cc, 4'h8, vcif_pkg::VCIF_OK_PHYS);
    tc(9'h14c, 4'h8, vcif_pkg::VCIF_UNDEF);
    tc(9'h18c, 4'h8, vcif_pkg::VCIF_TRAP_GUEST);
    tc(9'h1fc, 4'h8, vcif_pkg::VCIF_TRAP_HYP);
    tc(9'h1dc, 4'h9, vcif_pkg::VCIF_OK_VIRT);
    tc(9'h1ec, 4'h9, vcif_pkg::VCIF_OK_VIRT);
    tc(9'h1c4, 4'h8, vcif_pkg::VCIF_OK_PHYS);
    tc(9'h1c8, 4'h9, vcif_pkg::VCIF_OK_PHYS);
    tc(9'h1ce, 4'h8, vcif_pkg::VCIF_TRAP_HYP);
    tc(9'h1ce, 4'h9, vcif_pkg::VCIF_OK_VIRT);
    tc(9'h1cd, 4'h9, vcif_pkg::VCIF_TRAP_HYP);
    tc(9'h1cc, 4'h7, vcif_pkg::VCIF_UNDEF);
    // a non-guest level must reach the physical copy only
    req_level = 2'h2;
    tc(9'h1cc, 4'h8, vcif_pkg::VCIF_OK_PHYS);
    req_level = vcif_pkg::LVL_GUEST;
    ax(1'h0, vcif_pkg::CRM_GRP0, 3'h4, 32'h0);
    chk("ap0 kept", rd, 32'h100);
    pulse(1'h0, 1'h0, 8'h0);
    pulse(1'h1, 1'h1, 8'hc0);
    ax(1'h0, vcif_pkg::CRM_GRP1, 3'h3, 32'h0);
    chk("ap1 w3", rd, 32'h1);
    ax(1'h1, vcif_pkg::CRM_GRP1, 3'h3, rd);
    pulse(1'h0, 1'h1, 8'h0);
    chk("g0 act", 32'(group0_active), 32'h0);
    chk("g1 act", 32'(group1_active), 32'h0);
    test_done();
  end
endmodule : tb_vcif_prio_regs
